//--- hdl/lmc_mode_regs.sv
/*
 * lmc_mode_regs: mode control register bank of an lcd controller with
 * clock strobe generation, pixel blank/invert, frame repeat counter,
 * panel power sequencing and the two shared aux pins.
 * assumes: one clock mclk; the register master uses a plain strobe port
 * with read data one cycle after the read strobe; pixel data arrive
 * already through the colour lookup; frame_start is a same-domain pulse.
 */
`timescale 1ns/10ps
module lmc_mode_regs (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // register port
   input  wire logic [16:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // pixel path
   input  wire logic [7:0]  pixel_in,
   input  wire logic        pixel_valid,
   input  wire logic        frame_start,
   output logic      [7:0]  panel_data_lines,
   output logic             panel_data_valid,
   output logic             pattern_restart,
   output logic      [17:0] frame_count,
   // clock strobes and mode status
   output logic             op_tick,
   output logic             pixel_tick,
   output logic             mem_tick,
   output logic      [3:0]  pixel_bits,
   // panel power
   output logic             panel_power_out,
   output logic             panel_signals_on,
   // panel data pin eleven / aux io four
   input  wire logic        panel_data_pin_eleven_in,
   output logic             panel_data_pin_eleven_out,
   output logic             panel_data_pin_eleven_oe_n,
   // aux io zero
   input  wire logic        aux_io_zero_in,
   output logic             aux_io_zero_out,
   output logic             aux_io_zero_oe_n
);

   ////////////////////////////////////////////////////////////////////
   // registers

   logic [7:0] mode_control_one;
   logic [7:0] mode_control_two;
   logic [7:0] panel_config;
   logic [7:0] aux_config;
   logic [7:0] aux_control;
   logic [7:0] rotate_mode;
   logic [7:0] status_word;

   logic [1:0] pin_sync;
   logic       pin_eleven_lvl;
   logic       aux_zero_lvl;

   logic       passive_panel;
   logic       colour_panel;
   logic [1:0] depth_code;
   logic       depth_bad;
   logic       rotated;
   logic       hw_inv_active;
   logic       invert;
   logic       hw_ps_active;
   logic       power_save;
   logic       half_phase;
   logic [1:0] mem_div;

   lmc_pkg::lmc_pwr_t pwr_state;
   lmc_pkg::lmc_pwr_t next_pwr_state;
   logic [7:0]        seq_count;
   logic              seq_done;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         mode_control_one <= lmc_pkg::RST_ZERO;
      end else if (reg_wr && reg_addr == lmc_pkg::OFF_MODE_ONE) begin
         mode_control_one <= reg_wdata;
      end
   end

   // upper nibble is not implemented and reads as zero
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         mode_control_two <= lmc_pkg::RST_ZERO;
      end else if (reg_wr && reg_addr == lmc_pkg::OFF_MODE_TWO) begin
         mode_control_two <= reg_wdata & lmc_pkg::M2_WR_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         panel_config <= lmc_pkg::RST_ZERO;
      end else if (reg_wr && reg_addr == lmc_pkg::OFF_PANEL_CFG) begin
         panel_config <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         aux_config  <= lmc_pkg::RST_ZERO;
         aux_control <= lmc_pkg::RST_ZERO;
      end else begin
         if (reg_wr && reg_addr == lmc_pkg::OFF_AUX_CFG) begin
            aux_config <= reg_wdata;
         end
         if (reg_wr && reg_addr == lmc_pkg::OFF_AUX_CTRL) begin
            aux_control <= reg_wdata;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rotate_mode <= lmc_pkg::RST_ZERO;
      end else if (reg_wr && reg_addr == lmc_pkg::OFF_ROTATE) begin
         rotate_mode <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read port: data stand in the cycle after the strobe only

   always_comb begin
      status_word = 8'h00;
      status_word[lmc_pkg::ST_PWR_SAVE] = power_save;
      status_word[lmc_pkg::ST_PWR_ON] = panel_power_out;
      status_word[lmc_pkg::ST_DEPTH_BAD] = depth_bad;
      status_word[lmc_pkg::AUX_FOUR] = pin_eleven_lvl;
      status_word[lmc_pkg::AUX_ZERO] = aux_zero_lvl;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         reg_rdata <= lmc_pkg::RST_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            lmc_pkg::OFF_PANEL_CFG: reg_rdata <= panel_config;
            lmc_pkg::OFF_MODE_ONE:  reg_rdata <= mode_control_one;
            lmc_pkg::OFF_MODE_TWO:  reg_rdata <= mode_control_two;
            lmc_pkg::OFF_AUX_CFG:   reg_rdata <= aux_config;
            lmc_pkg::OFF_AUX_CTRL:  reg_rdata <= aux_control;
            lmc_pkg::OFF_ROTATE:    reg_rdata <= rotate_mode;
            lmc_pkg::OFF_STATUS:    reg_rdata <= status_word;
            default:                reg_rdata <= lmc_pkg::RST_ZERO;
         endcase
      end else begin
         reg_rdata <= lmc_pkg::RST_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers

   lmc_sync #(
      .W        (2)
   ) u_pin_sync (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .async_in ({panel_data_pin_eleven_in, aux_io_zero_in}),
      .sync_out (pin_sync)
   );

   assign pin_eleven_lvl = pin_sync[1];
   assign aux_zero_lvl   = pin_sync[0];

   ////////////////////////////////////////////////////////////////////
   // depth and clock strobes

   assign passive_panel = !panel_config[lmc_pkg::PC_ACTIVE];
   assign colour_panel  = panel_config[lmc_pkg::PC_COLOUR];
   assign depth_code    = mode_control_one[lmc_pkg::M1_DEPTH_HI:lmc_pkg::M1_DEPTH_LO];
   assign rotated       = rotate_mode[lmc_pkg::RO_ENABLE];

   // code 11 is only legal on a colour panel; gray panels fall back to 4 pixel bits, the memory divide still follows code 11
   assign depth_bad = (depth_code == lmc_pkg::DEPTH_8) && !colour_panel;

   always_comb begin
      unique case (depth_code)
         lmc_pkg::DEPTH_1: pixel_bits = 4'h1;
         lmc_pkg::DEPTH_2: pixel_bits = 4'h2;
         lmc_pkg::DEPTH_4: pixel_bits = 4'h4;
         lmc_pkg::DEPTH_8: pixel_bits = depth_bad ? 4'h4 : 4'h8;
      endcase
   end

   // operating clock is mclk itself or every other mclk edge
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         half_phase <= 1'b0;
      end else begin
         half_phase <= !half_phase;
      end
   end

   assign op_tick = mode_control_one[lmc_pkg::M1_CLK_HALF] ? half_phase : 1'b1;

   // landscape pixel rate is the operating rate; rotated mode uses the same
   // base and picks its memory divide from the rotate register
   assign pixel_tick = op_tick;

   always_comb begin
      if (rotated) begin
         mem_div = rotate_mode[lmc_pkg::RO_DIV_HI:lmc_pkg::RO_DIV_LO];
      end else if (mode_control_one[lmc_pkg::M1_HIGH_PERF]) begin
         mem_div = lmc_pkg::DIV_1;
      end else begin
         unique case (depth_code)
            lmc_pkg::DEPTH_1: mem_div = lmc_pkg::DIV_8;
            lmc_pkg::DEPTH_2: mem_div = lmc_pkg::DIV_4;
            lmc_pkg::DEPTH_4: mem_div = lmc_pkg::DIV_2;
            lmc_pkg::DEPTH_8: mem_div = lmc_pkg::DIV_1;
         endcase
      end
   end

   lmc_tick_div u_mem_div (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .tick_in  (pixel_tick),
      .div_log2 (mem_div),
      .tick_out (mem_tick)
   );

   ////////////////////////////////////////////////////////////////////
   // frame repeat counter

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         frame_count     <= 18'h0_0000;
         pattern_restart <= 1'b0;
      end else if (!mode_control_one[lmc_pkg::M1_FRAME_REP]) begin
         frame_count     <= 18'h0_0000;
         pattern_restart <= 1'b0;
      end else if (frame_start) begin
         frame_count     <= (frame_count == lmc_pkg::FRAME_LAST) ? 18'h0_0000 : 18'(frame_count + 18'h1);
         pattern_restart <= (frame_count == lmc_pkg::FRAME_LAST);
      end else begin
         pattern_restart <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power save and panel power sequencing

   // hardware request ignores the aux pin config and control bits
   assign hw_ps_active = mode_control_two[lmc_pkg::M2_HW_PS_EN] && aux_zero_lvl;

   // reserved codes 01 and 10 are taken as normal operation
   assign power_save = hw_ps_active
                    || mode_control_two[lmc_pkg::M2_SW_PS_HI:lmc_pkg::M2_SW_PS_LO] == lmc_pkg::PS_SAVE;

   assign seq_done = (seq_count == lmc_pkg::SEQ_FRAMES);

   always_comb begin
      next_pwr_state = pwr_state;
      unique case (pwr_state)
         lmc_pkg::PWR_ON: begin
            if (power_save) begin
               next_pwr_state = lmc_pkg::PWR_DOWN;
            end
         end
         lmc_pkg::PWR_DOWN: begin
            if (!power_save) begin
               next_pwr_state = lmc_pkg::PWR_ON;
            end else if (seq_done) begin
               next_pwr_state = lmc_pkg::PWR_OFF;
            end
         end
         lmc_pkg::PWR_OFF: begin
            if (!power_save) begin
               next_pwr_state = lmc_pkg::PWR_UP;
            end
         end
         lmc_pkg::PWR_UP: begin
            if (power_save) begin
               next_pwr_state = lmc_pkg::PWR_DOWN;
            end else if (seq_done) begin
               next_pwr_state = lmc_pkg::PWR_ON;
            end
         end
      endcase
      // override skips the delays on entry to power save
      if (power_save && mode_control_two[lmc_pkg::M2_PWR_FORCE]) begin
         next_pwr_state = lmc_pkg::PWR_OFF;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pwr_state <= lmc_pkg::PWR_OFF;
      end else begin
         pwr_state <= next_pwr_state;
      end
   end

   // delays are counted in frames so they scale with the panel rate
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         seq_count <= 8'h00;
      end else if (next_pwr_state != pwr_state) begin
         seq_count <= 8'h00;
      end else if (frame_start && !seq_done) begin
         seq_count <= 8'(seq_count + 8'h1);
      end
   end

   // power goes down after the signals, in the same cycle as them under the override, and comes up before them
   assign panel_power_out  = (pwr_state != lmc_pkg::PWR_OFF)
                          && !(power_save && mode_control_two[lmc_pkg::M2_PWR_FORCE]);
   assign panel_signals_on = (pwr_state == lmc_pkg::PWR_ON) && !power_save;

   ////////////////////////////////////////////////////////////////////
   // pixel output: blank and invert after the lookup stage

   assign hw_inv_active = passive_panel && mode_control_one[lmc_pkg::M1_HW_INV_EN];

   always_comb begin
      if (hw_inv_active) begin
         invert = pin_eleven_lvl;
      end else begin
         invert = mode_control_one[lmc_pkg::M1_SW_INV];
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         panel_data_lines <= 8'h00;
         panel_data_valid <= 1'b0;
      end else begin
         panel_data_valid <= pixel_valid && panel_signals_on;
         if (mode_control_one[lmc_pkg::M1_BLANK] || !panel_signals_on) begin
            panel_data_lines <= 8'h00;
         end else if (pixel_valid) begin
            panel_data_lines <= invert ? ~pixel_in : pixel_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // shared pins

   // pin eleven: invert input in passive hardware mode, else aux io four
   assign panel_data_pin_eleven_out = aux_control[lmc_pkg::AUX_FOUR];
   assign panel_data_pin_eleven_oe_n = hw_inv_active || !aux_config[lmc_pkg::AUX_FOUR];

   // pin zero: power save input, plain input, or driven output
   assign aux_io_zero_out  = aux_control[lmc_pkg::AUX_ZERO];
   assign aux_io_zero_oe_n = mode_control_two[lmc_pkg::M2_HW_PS_EN]
                          || !aux_config[lmc_pkg::AUX_ZERO];

endmodule : lmc_mode_regs

//--- hdl/lmc_pkg.sv
/*
 * lmc_pkg: register offsets, field positions, reset values and shared
 * types for the lcd mode control register bank.
 * assumes: an 8-bit register port with a 17-bit byte address.
 */
package lmc_pkg;

   localparam int unsigned ADDR_W = 17;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [16:0] OFF_PANEL_CFG    = 17'h1_ffe1;
   localparam logic [16:0] OFF_MODE_ONE     = 17'h1_ffe2;
   localparam logic [16:0] OFF_MODE_TWO     = 17'h1_ffe3;
   localparam logic [16:0] OFF_AUX_CFG      = 17'h1_fff8;
   localparam logic [16:0] OFF_AUX_CTRL     = 17'h1_fff9;
   localparam logic [16:0] OFF_ROTATE       = 17'h1_fffb;
   localparam logic [16:0] OFF_STATUS       = 17'h1_fffc;

   // mode_control_one fields
   localparam int unsigned M1_DEPTH_HI = 7;
   localparam int unsigned M1_DEPTH_LO = 6;
   localparam int unsigned M1_HIGH_PERF = 5;
   localparam int unsigned M1_CLK_HALF = 4;
   localparam int unsigned M1_BLANK = 3;
   localparam int unsigned M1_FRAME_REP = 2;
   localparam int unsigned M1_HW_INV_EN = 1;
   localparam int unsigned M1_SW_INV = 0;

   // mode_control_two fields
   localparam int unsigned M2_PWR_FORCE = 3;
   localparam int unsigned M2_HW_PS_EN = 2;
   localparam int unsigned M2_SW_PS_HI = 1;
   localparam int unsigned M2_SW_PS_LO = 0;
   localparam logic [7:0]  M2_WR_MASK = 8'h0f;

   // panel_config fields
   localparam int unsigned PC_ACTIVE = 7;
   localparam int unsigned PC_COLOUR = 5;

   // aux io bit positions in aux_cfg / aux_ctrl / status
   localparam int unsigned AUX_ZERO = 0;
   localparam int unsigned AUX_FOUR = 4;

   // rotate register fields
   localparam int unsigned RO_ENABLE = 7;
   localparam int unsigned RO_DIV_HI = 1;
   localparam int unsigned RO_DIV_LO = 0;

   // status fields
   localparam int unsigned ST_PWR_SAVE = 7;
   localparam int unsigned ST_PWR_ON = 6;
   localparam int unsigned ST_DEPTH_BAD = 5;

   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;

   // depth codes and memory clock divide (log2)
   localparam logic [1:0] DEPTH_1 = 2'h0;
   localparam logic [1:0] DEPTH_2 = 2'h1;
   localparam logic [1:0] DEPTH_4 = 2'h2;
   localparam logic [1:0] DEPTH_8 = 2'h3;
   localparam logic [1:0] DIV_8 = 2'h3;
   localparam logic [1:0] DIV_4 = 2'h2;
   localparam logic [1:0] DIV_2 = 2'h1;
   localparam logic [1:0] DIV_1 = 2'h0;

   // software power save codes
   localparam logic [1:0] PS_SAVE = 2'h0;
   localparam logic [1:0] PS_NORMAL = 2'h3;

   // frame counter
   localparam int unsigned FRAME_W = 18;
   localparam logic [17:0] FRAME_LAST = 18'h3_ffff;

   // power sequencing delay in frames
   localparam logic [7:0] SEQ_FRAMES = 8'h80;

   typedef enum logic [1:0] {PWR_ON, PWR_DOWN, PWR_OFF, PWR_UP} lmc_pwr_t;

endpackage : lmc_pkg

//--- hdl/lmc_sync.sv
/*
 * lmc_sync: two flip-flop synchroniser, one per bit.
 * assumes: inputs are asynchronous pin levels; only the second stage
 * is read by logic outside.
 */
`timescale 1ns/10ps
module lmc_sync #(
   parameter int unsigned W = 2
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         reset_n,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] stage_one;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               stage_one[i] <= 1'b0;
               sync_out[i]  <= 1'b0;
            end else begin
               stage_one[i] <= async_in[i];
               sync_out[i]  <= stage_one[i];
            end
         end
      end
   endgenerate

endmodule : lmc_sync

//--- hdl/lmc_tick_div.sv
/*
 * lmc_tick_div: divides a strobe stream by 1, 2, 4 or 8.
 * assumes: tick_in is a one-cycle strobe on mclk; div_log2 may change
 * at any time, the counter simply restarts its compare.
 */
`timescale 1ns/10ps
module lmc_tick_div (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // strobes
   input  wire logic       tick_in,
   input  wire logic [1:0] div_log2,
   output logic            tick_out
);

   logic [2:0] count;
   logic [2:0] limit;

   always_comb begin
      limit = 3'((4'h1 << div_log2) - 4'h1);
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count <= 3'h0;
      end else if (tick_in) begin
         count <= (count >= limit) ? 3'h0 : 3'(count + 3'h1);
      end
   end

   // strobe on the last input tick of each group
   assign tick_out = tick_in && (count >= limit);

endmodule : lmc_tick_div

//--- test/lmc_mode_regs_monitor.sv
/* lmc_mode_regs_monitor: port checks for the mode register bank.
   assumes: bound to lmc_mode_regs; register shadows follow host writes. */
`timescale 1ns/10ps
module lmc_mode_regs_monitor (
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // register port
   input wire logic [16:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // pixel path and strobes
   input wire logic [7:0]  pixel_in,
   input wire logic        frame_start,
   input wire logic [7:0]  panel_data_lines,
   input wire logic        panel_data_valid,
   input wire logic [17:0] frame_count,
   input wire logic        op_tick,
   input wire logic        pixel_tick,
   input wire logic        mem_tick,
   // power and aux pin
   input wire logic        panel_power_out,
   input wire logic        panel_signals_on,
   input wire logic        aux_io_zero_oe_n
);
   logic [7:0] m1;
   logic [3:0] m2;
   logic       rot;
   logic       acfg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   // shadows avoid probing the body
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         m1   <= 8'h00;
         m2   <= 4'h0;
         rot  <= 1'b0;
         acfg <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == lmc_pkg::OFF_MODE_ONE) m1 <= reg_wdata;
         if (reg_addr == lmc_pkg::OFF_MODE_TWO) m2 <= reg_wdata[3:0];
         if (reg_addr == lmc_pkg::OFF_ROTATE) rot <= reg_wdata[7];
         if (reg_addr == lmc_pkg::OFF_AUX_CFG) acfg <= reg_wdata[0];
      end
   end
   sequence s_rd_one;
      reg_rd && reg_addr == lmc_pkg::OFF_MODE_ONE;
   endsequence
   sequence s_rd_two;
      reg_rd && reg_addr == lmc_pkg::OFF_MODE_TWO;
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_read_one: assert property (s_rd_one |=> reg_rdata == $past(m1))
      else $error("mode one read back wrong");
   a_two_mask: assert property (s_rd_two |=> reg_rdata == {4'h0, $past(m2)})
      else $error("mode two read back wrong");
   a_blank_low: assert property (panel_data_valid && $past(m1[3]) |-> panel_data_lines == 8'h00)
      else $error("blanked data not low");
   a_sw_invert: assert property (panel_data_valid && ($past(m1) & 8'h0e) == 8'h00 |->
      panel_data_lines == ($past(m1[0]) ? ~$past(pixel_in) : $past(pixel_in)))
      else $error("software invert wrong");
   a_hp_full: assert property (m1[5] && !rot |-> mem_tick == pixel_tick)
      else $error("memory strobe not at pixel rate");
   a_clk_full: assert property (!m1[4] && !rot |-> op_tick && pixel_tick)
      else $error("undivided clock strobe missing");
   a_clk_half: assert property (m1[4] && $past(m1[4]) |-> op_tick != $past(op_tick))
      else $error("halved clock not alternating");
   a_frame_step: assert property (frame_start && m1[2] && frame_count != 18'h3_ffff |=>
      frame_count == $past(frame_count) + 18'h0_0001)
      else $error("frame counter step wrong");
   a_force_off: assert property (m2[3] && m2[1:0] == 2'b00 |-> !panel_power_out && !panel_signals_on)
      else $error("override did not cut power");
   a_aux_dir: assert property (aux_io_zero_oe_n == (m2[2] || !acfg))
      else $error("aux pin zero direction wrong");
endmodule : lmc_mode_regs_monitor

bind lmc_mode_regs lmc_mode_regs_monitor u_mon (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pixel_in(pixel_in),
   .frame_start(frame_start), .panel_data_lines(panel_data_lines), .panel_data_valid(panel_data_valid),
   .frame_count(frame_count), .op_tick(op_tick), .pixel_tick(pixel_tick), .mem_tick(mem_tick),
   .panel_power_out(panel_power_out), .panel_signals_on(panel_signals_on),
   .aux_io_zero_oe_n(aux_io_zero_oe_n));

//--- test/lmc_panel_model.sv
/* lmc_panel_model: panel and board side of the shared pins.
   assumes: the bench sets the board request levels. */
`timescale 1ns/10ps
module lmc_panel_model (
   // clock
   input wire logic       mclk,
   // panel data
   input wire logic [7:0] panel_data_lines,
   input wire logic       panel_data_valid,
   input wire logic       panel_power_out,
   // shared pins
   input wire logic       p11_out,
   input wire logic       p11_oe_n,
   input wire logic       invert_req,
   input wire logic       a0_out,
   input wire logic       a0_oe_n,
   input wire logic       save_req,
   output logic           p11_lvl,
   output logic           a0_lvl,
   output logic [7:0]     last_pixel
);
   ////////////////////////////////////////
   // the board only wins while the device leaves the pin undriven
   assign p11_lvl = p11_oe_n ? invert_req : p11_out;
   assign a0_lvl  = a0_oe_n ? save_req : a0_out;
   // an unpowered panel shows a changing pattern, not the last pixel
   always_ff @(posedge mclk) begin
      if (!panel_power_out) last_pixel <= ~last_pixel;
      else if (panel_data_valid) last_pixel <= panel_data_lines;
   end
endmodule : lmc_panel_model

//--- test/lmc_mode_regs_test.sv
/* lmc_mode_regs_test: directed bench for the mode register bank.
   assumes: bound monitor and panel model under test/. */
`timescale 1ns/10ps
module lmc_mode_regs_test;
   localparam logic [16:0] PIX [8] = '{17'h0_003c, 17'h0_02c3, 17'h0_1200, 17'h0_043c,
                                      17'h0_05c3, 17'h0_063c, 17'h0_07c3, 17'h0_013c};
   // rotate, mode one, depth bits, memory strobes, operating strobes; hp row brackets an update
   localparam logic [35:0] CLK [7] = '{36'h0_0001_0840, 36'h0_0402_1040, 36'h0_0804_2040, 36'h0_0c08_4040,
                                      36'h0_0201_4040, 36'h0_0d08_2020, 36'h8_2e08_1040};
   logic mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pixel_valid = 1'b0;
   logic frame_start = 1'b0, invert_req = 1'b0, save_req = 1'b0;
   logic [16:0] reg_addr = 17'h0_0000;
   logic [7:0]  reg_wdata = 8'h00, pixel_in = 8'h00, reg_rdata, panel_data_lines, last_pixel;
   logic [17:0] frame_count;
   logic [3:0]  pixel_bits;
   logic op_tick, pixel_tick, mem_tick, panel_power_out, panel_signals_on, panel_data_valid;
   logic p11_out, p11_oe_n, p11_lvl, a0_out, a0_oe_n, a0_lvl;
   int bad_count = 0;
   int checked = 0;
   always #10 mclk = ~mclk;
   lmc_mode_regs dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pixel_in(pixel_in), .pixel_valid(pixel_valid),
      .frame_start(frame_start), .panel_data_lines(panel_data_lines), .panel_data_valid(panel_data_valid),
      .pattern_restart(), .frame_count(frame_count), .op_tick(op_tick), .pixel_tick(pixel_tick),
      .mem_tick(mem_tick), .pixel_bits(pixel_bits), .panel_power_out(panel_power_out),
      .panel_signals_on(panel_signals_on), .panel_data_pin_eleven_in(p11_lvl),
      .panel_data_pin_eleven_out(p11_out), .panel_data_pin_eleven_oe_n(p11_oe_n),
      .aux_io_zero_in(a0_lvl), .aux_io_zero_out(a0_out), .aux_io_zero_oe_n(a0_oe_n));
   lmc_panel_model u_panel (.mclk(mclk), .panel_data_lines(panel_data_lines),
      .panel_data_valid(panel_data_valid), .panel_power_out(panel_power_out), .p11_out(p11_out),
      .p11_oe_n(p11_oe_n), .invert_req(invert_req), .a0_out(a0_out), .a0_oe_n(a0_oe_n),
      .save_req(save_req), .p11_lvl(p11_lvl), .a0_lvl(a0_lvl), .last_pixel(last_pixel));
   ////////////////////////////////////////
   task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic stop_test;
      if (bad_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [16:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 cmp(18'(reg_rdata), 18'(e));
   endtask : rd
   task automatic fr(input int n);
      repeat (n) begin
         @(posedge mclk);
         frame_start <= 1'b1;
         @(posedge mclk);
         frame_start <= 1'b0;
      end
   endtask : fr
   task automatic t_regs;
      rd(lmc_pkg::OFF_MODE_ONE, 8'h00);
      rd(lmc_pkg::OFF_MODE_TWO, 8'h00);
      wr(lmc_pkg::OFF_MODE_ONE, 8'ha5);
      rd(lmc_pkg::OFF_MODE_ONE, 8'ha5);
      wr(lmc_pkg::OFF_MODE_TWO, 8'hfc);
      rd(lmc_pkg::OFF_MODE_TWO, 8'h0c);
      wr(17'h1_ffe4, 8'h5a);
      rd(17'h1_ffe4, 8'h00);
      wr(lmc_pkg::OFF_MODE_ONE, 8'h00);
      wr(lmc_pkg::OFF_MODE_TWO, 8'h01);
      repeat (2) @(posedge mclk);
      #1 cmp(18'(panel_power_out), 18'h1);
      fr(127);
      #1 cmp(18'(panel_signals_on), 18'h0);
      fr(1);
      repeat (2) @(posedge mclk);
      #1 cmp(18'(panel_signals_on), 18'h1);
   endtask : t_regs
   task automatic t_pixels;
      for (int i = 0; i < 8; i++) begin
         wr(lmc_pkg::OFF_MODE_ONE, PIX[i][16:9]);
         invert_req <= PIX[i][8];
         repeat (3) @(posedge mclk);
         pixel_in <= 8'h3c;
         pixel_valid <= 1'b1;
         @(posedge mclk);
         pixel_valid <= 1'b0;
         #1 cmp(18'(panel_data_lines), 18'(PIX[i][7:0]));
         @(posedge mclk);
         #1 cmp(18'(last_pixel), 18'(PIX[i][7:0]));
      end
   endtask : t_pixels
   task automatic t_clocks;
      int m;
      int o;
      wr(lmc_pkg::OFF_PANEL_CFG, 8'h20);
      for (int i = 0; i < 7; i++) begin
         wr(lmc_pkg::OFF_ROTATE, CLK[i][35:28]);
         wr(lmc_pkg::OFF_MODE_ONE, CLK[i][27:20]);
         repeat (4) @(posedge mclk);
         #1 cmp(18'(pixel_bits), 18'(CLK[i][19:16]));
         m = 0;
         o = 0;
         repeat (64) begin
            @(negedge mclk);
            m += int'(mem_tick);
            o += int'(op_tick);
         end
         cmp(18'(m), 18'(CLK[i][15:8]));
         cmp(18'(o), 18'(CLK[i][7:0]));
      end
      wr(lmc_pkg::OFF_ROTATE, 8'h00);
      wr(lmc_pkg::OFF_PANEL_CFG, 8'h00);
      #1 cmp(18'(pixel_bits), 18'h4);
      wr(lmc_pkg::OFF_MODE_ONE, 8'h04);
      fr(5);
      #1 cmp(frame_count, 18'h0_0005);
      wr(lmc_pkg::OFF_MODE_ONE, 8'h00);
      repeat (2) @(posedge mclk);
      #1 cmp(frame_count, 18'h0_0000);
   endtask : t_clocks
   task automatic t_save;
      wr(lmc_pkg::OFF_AUX_CFG, 8'h11);
      wr(lmc_pkg::OFF_AUX_CTRL, 8'h11);
      #1 cmp(18'({a0_oe_n, a0_out, p11_oe_n, p11_out}), 18'h5);
      wr(lmc_pkg::OFF_MODE_TWO, 8'h07);
      save_req <= 1'b1;
      #1 cmp(18'(a0_oe_n), 18'h1);
      repeat (4) @(posedge mclk);
      #1 cmp(18'({panel_power_out, panel_signals_on}), 18'h2);
      wr(lmc_pkg::OFF_MODE_TWO, 8'h0f);
      #1 cmp(18'(panel_power_out), 18'h0);
      wr(lmc_pkg::OFF_MODE_TWO, 8'h08);
      wr(lmc_pkg::OFF_AUX_CFG, 8'h00);
      repeat (3) @(posedge mclk);
      rd(lmc_pkg::OFF_STATUS, 8'h91);
   endtask : t_save
   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs();
      t_pixels();
      t_clocks();
      t_save();
      stop_test();
   end
   initial begin
      #1ms;
      bad_count++;
      stop_test();
   end
endmodule : lmc_mode_regs_test
